// ### rtl/asf_consts.svh
// asf_consts.svh: codes, field slices and counts of the response/stream framer
// assumes inclusion by bare name from files under rtl/
`ifndef ASF_CONSTS_SVH
`define ASF_CONSTS_SVH
// transaction codes
`define ASF_TC_WR_RESP   4'h2
`define ASF_TC_QRD_RESP  4'h6
`define ASF_TC_BRD_RESP  4'h7
`define ASF_TC_CYC_START 4'h8
`define ASF_TC_STREAM    4'ha
`define ASF_TC_LOCK_RESP 4'hb
// fixed field values
`define ASF_RETRY_X      2'b01
`define ASF_LOCAL_BUS    10'h3ff
`define ASF_SPD_MAX      3'h2
`define ASF_PRI_ZERO     4'h0
`define ASF_RESV_12      12'h000
`define ASF_QUAD_ZERO    32'h0000_0000
`define ASF_COUNT_ZERO   16'h0000
`define ASF_IDX_ZERO     2'h0
`define ASF_SPD_ZERO     3'h0
// internal quadlet 0 fields
`define ASF_F_SRC_BUS    23
`define ASF_F_SPD        18:16
`define ASF_F_TRANSACTION_LABEL     15:10
`define ASF_F_TCODE      7:4
`define ASF_F_TAG        15:14
`define ASF_F_CHAN       13:8
`define ASF_F_SY         3:0
// upper half: destination, length; response code below it
`define ASF_F_HI16       31:16
`define ASF_F_RESPONSE_CODE      15:12
// counts and indices
`define ASF_QUAD_BYTES   16'h0004
`define ASF_HDR_STREAM   2'h1
`define ASF_HDR_WRRESP   2'h2
`define ASF_HDR_RESP     2'h3
`define ASF_WIRE_STREAM  2'h0
`define ASF_WIRE_WRRESP  2'h2
`define ASF_WIRE_RESP    2'h3
`define ASF_WIRE_Q0      2'h0
`define ASF_WIRE_Q1      2'h1
`define ASF_WIRE_Q2      2'h2
`define ASF_IDX_Q1       2'h1
`define ASF_IDX_Q3       2'h3
`define ASF_IDX_STEP     2'h1
`endif

// ### rtl/asf_pkg.sv
// asf_pkg: types shared by the framer and its buffer
// assumes nothing beyond a SystemVerilog compiler
package asf_pkg;
  typedef logic [31:0] asf_quad_t;
  typedef logic [15:0] asf_count_t;
  typedef enum logic [2:0] {
    ASF_TX_IDLE,
    ASF_TX_HDR,
    ASF_TX_WIRE,
    ASF_TX_PAY,
    ASF_TX_DROP
  } asf_tx_state_t;
endpackage : asf_pkg

// ### rtl/asf_stream_if.sv
// asf_stream_if: quadlet stream with valid/ready and end-of-packet mark
// assumes asf_pkg compiled first
interface asf_stream_if;
  import asf_pkg::*;
  logic      valid;
  logic      ready;
  logic      last;
  asf_quad_t data;
  modport src (output valid, output data, output last, input ready);
  modport snk (input valid, input data, input last, output ready);
endinterface : asf_stream_if

// ### rtl/asf_skid_buffer.sv
// asf_skid_buffer: two-entry buffer, registered outputs on both sides
// assumes one clock; a stalled drain side loses no word
`include "asf_consts.svh"
module asf_skid_buffer (
  // clock and reset
  input wire logic   clk,
  input wire logic   rst_n,
  // streams
  asf_stream_if.snk  inS,
  asf_stream_if.src  outS
);
  import asf_pkg::*;

  logic      skidValid;
  logic      skidLast;
  asf_quad_t skidData;
  logic      inFire;

  // ready is a flop: the spare entry absorbs the word in flight
  assign inS.ready = !skidValid;
  assign inFire    = inS.valid && !skidValid;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      outS.valid <= 1'b0;
      outS.data  <= `ASF_QUAD_ZERO;
      outS.last  <= 1'b0;
    end else if (!outS.valid || outS.ready) begin
      outS.valid <= skidValid || inFire;
      outS.data  <= skidValid ? skidData : inS.data;
      outS.last  <= skidValid ? skidLast : inS.last;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      skidValid <= 1'b0;
      skidData  <= `ASF_QUAD_ZERO;
      skidLast  <= 1'b0;
    end else if (!outS.valid || outS.ready) begin
      skidValid <= 1'b0;
    end else if (inFire) begin
      skidValid <= 1'b1;
      skidData  <= inS.data;
      skidLast  <= inS.last;
    end
  end
endmodule : asf_skid_buffer

// ### rtl/asf_tx_format.sv
// asf_tx_format: builds wire response and stream packets from the internal
// quadlet format, and steers received packets into two buffer-fill contexts
// assumes payload quadlets arrive msb-first, already realigned upstream
// How it works
// - quadlet read response is four quadlets: destination, source with response_code, zero, data.
// - block and lock responses carry length and extended code in quadlet four.
// - first payload byte of a block response sits in the top byte.
// - lengths not a multiple of four get zero bytes to a whole quadlet.
// - stream packets use isochronous layout, code 4'ha, async arbitration.
// - unaligned stream payloads accepted; the framer zero-pads the last quadlet.
// - stream fields: speed 3, tag 2, channel 6, code 4, sync 4, length 16.
// - first stream byte goes to byte 0; last quadlet zero completed.
// - wire packets are rebuilt; speed never appears in the stream header.
// - receive side takes all offered packets but never stores cycle starts.
// - two receive contexts, requests and responses, each with its own buffers.
// - packets are concatenated back to back into each context's buffers.
// - speed code 0 is 100, 1 is 200, 2 is 400; others reserved.
// - source bus is 10'h3ff when selector clear, else the node's bus number.
// - retry code sent as 2'b01, the single-phase retry constant.
`include "asf_consts.svh"
module asf_tx_format (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // node identity
  input  wire logic [9:0]    busNumber,
  input  wire logic [5:0]    nodeNumber,
  // internal-format transmit input
  input  wire logic          txInValid,
  output      logic          txInReady,
  input  wire asf_pkg::asf_quad_t txInData,
  input  wire logic          txInLast,
  // wire transmit output
  output      logic          txOutValid,
  input  wire logic          txOutReady,
  output      asf_pkg::asf_quad_t txOutData,
  output      logic          txOutLast,
  output      logic [2:0]    txSpeed,
  output      logic          txSpeedReserved,
  output      logic          txIsStream,
  output      logic          txFormatError,
  // receive quadlets from the link
  input  wire logic          rxValid,
  output      logic          rxReady,
  input  wire asf_pkg::asf_quad_t rxData,
  input  wire logic          rxFirst,
  // buffer program, index 0 requests, 1 responses
  input  wire logic [1:0]    bufLoad,
  input  wire logic [31:0]   bufAddr [2],
  input  wire asf_pkg::asf_count_t bufCount [2],
  output      asf_pkg::asf_count_t resCount [2],
  // host memory writes
  output      logic          memWrValid,
  output      logic          memWrCtx,
  output      logic [31:0]   memWrAddr,
  output      asf_pkg::asf_quad_t memWrData,
  output      logic          rxDropped
);
  import asf_pkg::*;

  asf_stream_if fmt ();
  asf_stream_if outS ();

  asf_skid_buffer uBuf (
    .clk   (clk),
    .rst_n (rst_n),
    .inS   (fmt),
    .outS  (outS)
  );

  assign txOutValid = outS.valid;
  assign txOutData  = outS.data;
  assign txOutLast  = outS.last;
  assign outS.ready = txOutReady;

  // ---------------- transmit framing ----------------

  function automatic logic tcKnown(input logic [3:0] tc);
    tcKnown = (tc == `ASF_TC_WR_RESP) || (tc == `ASF_TC_QRD_RESP) ||
              (tc == `ASF_TC_BRD_RESP) || (tc == `ASF_TC_LOCK_RESP) ||
              (tc == `ASF_TC_STREAM);
  endfunction : tcKnown

  // last internal header index per code
  function automatic logic [1:0] lastHdrOf(input logic [3:0] tc);
    if (tc == `ASF_TC_STREAM) begin
      lastHdrOf = `ASF_HDR_STREAM;
    end else if (tc == `ASF_TC_WR_RESP) begin
      lastHdrOf = `ASF_HDR_WRRESP;
    end else begin
      lastHdrOf = `ASF_HDR_RESP;
    end
  endfunction : lastHdrOf

  function automatic logic [1:0] lastWireOf(input logic [3:0] tc);
    if (tc == `ASF_TC_STREAM) begin
      lastWireOf = `ASF_WIRE_STREAM;
    end else if (tc == `ASF_TC_WR_RESP) begin
      lastWireOf = `ASF_WIRE_WRRESP;
    end else begin
      lastWireOf = `ASF_WIRE_RESP;
    end
  endfunction : lastWireOf

  // keeps only the bytes still owed; the rest become zero padding
  function automatic asf_quad_t padMask(input asf_count_t rem);
    case (rem)
      16'h0001: padMask = 32'hff00_0000;
      16'h0002: padMask = 32'hffff_0000;
      16'h0003: padMask = 32'hffff_ff00;
      default:  padMask = 32'hffff_ffff;
    endcase
  endfunction : padMask

  asf_tx_state_t state;
  asf_quad_t     hdr [4];
  logic [1:0]    hdrIdx;
  logic [1:0]    wireIdx;
  asf_count_t    txRemain;
  logic [3:0]    tcode;
  logic [3:0]    inTcode;
  logic [9:0]    srcBus;
  asf_count_t    payLen;
  logic          hasPay;
  logic          inFire;
  asf_quad_t     wireWord;

  assign tcode   = hdr[0][`ASF_F_TCODE];
  assign inTcode = txInData[`ASF_F_TCODE];
  assign srcBus  = hdr[0][`ASF_F_SRC_BUS] ? busNumber : `ASF_LOCAL_BUS;
  assign payLen  = (tcode == `ASF_TC_STREAM) ? hdr[`ASF_IDX_Q1][`ASF_F_HI16]
                                             : hdr[`ASF_IDX_Q3][`ASF_F_HI16];
  assign hasPay  = (tcode == `ASF_TC_STREAM) || (tcode == `ASF_TC_BRD_RESP) ||
                   (tcode == `ASF_TC_LOCK_RESP);

  assign txInReady = (state == ASF_TX_IDLE) || (state == ASF_TX_HDR) ||
                     (state == ASF_TX_DROP) || ((state == ASF_TX_PAY) && fmt.ready);
  assign inFire    = txInValid && txInReady;

  // wire header words, standard serial bus positions
  always_comb begin
    wireWord = `ASF_QUAD_ZERO;
    if (tcode == `ASF_TC_STREAM) begin
      // speed left out of the wire header
      wireWord = {payLen, hdr[0][`ASF_F_TAG], hdr[0][`ASF_F_CHAN],
                  `ASF_TC_STREAM, hdr[0][`ASF_F_SY]};
    end else begin
      case (wireIdx)
        `ASF_WIRE_Q0: wireWord = {hdr[`ASF_IDX_Q1][`ASF_F_HI16], hdr[0][`ASF_F_TRANSACTION_LABEL],
                                  `ASF_RETRY_X, tcode, `ASF_PRI_ZERO};
        `ASF_WIRE_Q1: wireWord = {srcBus, nodeNumber,
                                  hdr[`ASF_IDX_Q1][`ASF_F_RESPONSE_CODE], `ASF_RESV_12};
        `ASF_WIRE_Q2: wireWord = `ASF_QUAD_ZERO;
        // read data, or length with lock code passed through
        default:      wireWord = hdr[`ASF_IDX_Q3];
      endcase
    end
  end

  always_comb begin
    fmt.valid = 1'b0;
    fmt.data  = `ASF_QUAD_ZERO;
    fmt.last  = 1'b0;
    if (state == ASF_TX_WIRE) begin
      fmt.valid = 1'b1;
      fmt.data  = wireWord;
      fmt.last  = (wireIdx == lastWireOf(tcode)) && !(hasPay && (payLen != `ASF_COUNT_ZERO));
    end else if (state == ASF_TX_PAY) begin
      // payload follows header at once, first byte in the top byte
      fmt.valid = txInValid;
      fmt.data  = txInData & padMask(txRemain);
      fmt.last  = (txRemain <= `ASF_QUAD_BYTES);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state    <= ASF_TX_IDLE;
      hdrIdx   <= `ASF_IDX_ZERO;
      wireIdx  <= `ASF_IDX_ZERO;
      txRemain <= `ASF_COUNT_ZERO;
    end else begin
      case (state)
        ASF_TX_IDLE: begin
          if (inFire) begin
            hdrIdx <= `ASF_IDX_STEP;
            if (!tcKnown(inTcode)) begin
              state <= txInLast ? ASF_TX_IDLE : ASF_TX_DROP;
            end else begin
              state <= ASF_TX_HDR;
            end
          end
        end
        ASF_TX_HDR: begin
          if (inFire) begin
            hdrIdx <= hdrIdx + `ASF_IDX_STEP;
            if (hdrIdx == lastHdrOf(tcode)) begin
              state   <= ASF_TX_WIRE;
              wireIdx <= `ASF_IDX_ZERO;
            end
          end
        end
        ASF_TX_WIRE: begin
          if (fmt.ready) begin
            wireIdx <= wireIdx + `ASF_IDX_STEP;
            if (wireIdx == lastWireOf(tcode)) begin
              txRemain <= payLen;
              state    <= (hasPay && (payLen != `ASF_COUNT_ZERO)) ? ASF_TX_PAY : ASF_TX_IDLE;
            end
          end
        end
        ASF_TX_PAY: begin
          if (inFire) begin
            txRemain <= (txRemain <= `ASF_QUAD_BYTES) ? `ASF_COUNT_ZERO
                                                      : txRemain - `ASF_QUAD_BYTES;
            if (txRemain <= `ASF_QUAD_BYTES) begin
              state <= ASF_TX_IDLE;
            end
          end
        end
        ASF_TX_DROP: begin
          if (inFire && txInLast) begin
            state <= ASF_TX_IDLE;
          end
        end
        default: state <= ASF_TX_IDLE;
      endcase
    end
  end

  // header capture; quadlet 0 taken straight off the input
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        hdr[i] <= `ASF_QUAD_ZERO;
      end
    end else if (inFire && (state == ASF_TX_IDLE)) begin
      hdr[0] <= txInData;
    end else if (inFire && (state == ASF_TX_HDR)) begin
      hdr[hdrIdx] <= txInData;
    end
  end

  // speed travels beside the packet, decided when the header completes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txSpeed         <= `ASF_SPD_ZERO;
      txSpeedReserved <= 1'b0;
      txIsStream      <= 1'b0;
      txFormatError   <= 1'b0;
    end else begin
      txFormatError <= inFire && (state == ASF_TX_IDLE) && !tcKnown(inTcode);
      if (inFire && (state == ASF_TX_HDR) && (hdrIdx == lastHdrOf(tcode))) begin
        txSpeed         <= hdr[0][`ASF_F_SPD];
        txSpeedReserved <= hdr[0][`ASF_F_SPD] > `ASF_SPD_MAX;
        txIsStream      <= (tcode == `ASF_TC_STREAM);
      end
    end
  end

  // ---------------- receive contexts ----------------

  logic        holdValid;
  asf_quad_t   holdData;
  logic        holdFirst;
  logic        pktCtx;
  logic        pktDrop;
  logic        curCtx;
  logic        curDrop;
  logic        drain;
  logic        rxFire;
  logic [3:0]  rxTcode;
  logic        nextHold;
  logic [31:0] wAddr [2];

  function automatic logic isResp(input logic [3:0] tc);
    isResp = (tc == `ASF_TC_WR_RESP) || (tc == `ASF_TC_QRD_RESP) ||
             (tc == `ASF_TC_BRD_RESP) || (tc == `ASF_TC_LOCK_RESP);
  endfunction : isResp

  assign rxTcode  = holdData[`ASF_F_TCODE];
  assign curCtx   = holdFirst ? isResp(rxTcode) : pktCtx;
  assign curDrop  = holdFirst ? (rxTcode == `ASF_TC_CYC_START) : pktDrop;
  // a full buffer stalls the link rather than dropping words
  assign drain    = holdValid && (curDrop || (resCount[curCtx] >= `ASF_QUAD_BYTES));
  assign rxFire   = rxValid && rxReady;
  assign nextHold = (holdValid && !drain) || rxFire;

  // one-word holding stage; throughput halves for the sake of a flopped ready
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      holdValid <= 1'b0;
      holdData  <= `ASF_QUAD_ZERO;
      holdFirst <= 1'b0;
      rxReady   <= 1'b0;
    end else begin
      holdValid <= nextHold;
      rxReady   <= !nextHold;
      if (rxFire) begin
        holdData  <= rxData;
        holdFirst <= rxFirst;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pktCtx  <= 1'b0;
      pktDrop <= 1'b0;
    end else if (drain && holdFirst) begin
      pktCtx  <= curCtx;
      pktDrop <= curDrop;
    end
  end

  generate
    for (genvar g = 0; g < 2; g++) begin : gCtx
      // concatenate packets; a packet may straddle into the next buffer
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          resCount[g] <= `ASF_COUNT_ZERO;
          wAddr[g]    <= `ASF_QUAD_ZERO;
        end else if (bufLoad[g]) begin
          resCount[g] <= bufCount[g];
          wAddr[g]    <= bufAddr[g];
        end else if (drain && !curDrop && (curCtx == g[0])) begin
          resCount[g] <= resCount[g] - `ASF_QUAD_BYTES;
          wAddr[g]    <= wAddr[g] + {`ASF_COUNT_ZERO, `ASF_QUAD_BYTES};
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      memWrValid <= 1'b0;
      memWrCtx   <= 1'b0;
      memWrAddr  <= `ASF_QUAD_ZERO;
      memWrData  <= `ASF_QUAD_ZERO;
      rxDropped  <= 1'b0;
    end else begin
      memWrValid <= drain && !curDrop;
      memWrCtx   <= curCtx;
      memWrAddr  <= wAddr[curCtx];
      memWrData  <= holdData;
      rxDropped  <= drain && curDrop && holdFirst;
    end
  end
endmodule : asf_tx_format

// ### sim/asf_tx_format_chk.sv
// asf_tx_format_chk: port-level assertions for the response/stream framer
// assumes one clock domain with synchronous active-low reset
module asf_tx_format_chk (
  // clock and reset
  input wire logic                clk,
  input wire logic                rst_n,
  // transmit side
  input wire logic                txOutValid,
  input wire logic                txOutReady,
  input wire asf_pkg::asf_quad_t  txOutData,
  input wire logic                txOutLast,
  input wire logic [2:0]          txSpeed,
  input wire logic                txSpeedReserved,
  input wire logic                txFormatError,
  // receive side
  input wire logic                rxValid,
  input wire logic                rxReady,
  input wire asf_pkg::asf_quad_t  rxData,
  input wire logic                rxFirst,
  input wire logic [1:0]          bufLoad,
  input wire asf_pkg::asf_count_t bufCount [2],
  input wire asf_pkg::asf_count_t resCount [2],
  input wire logic                memWrValid,
  input wire logic                memWrCtx,
  input wire logic [31:0]         memWrAddr,
  input wire logic                rxDropped
);
  timeunit 1ns;
  timeprecision 1ps;
  import asf_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence csTake;
    rxValid && rxReady && rxFirst && rxData[7:4] == 4'h8;
  endsequence
  sequence wrNoLoad;
    memWrValid && !memWrCtx && bufLoad == 2'b00;
  endsequence
  // a stalled word must stand untouched, else the link loses it
  a_tx_stall_hold: assert property (txOutValid && !txOutReady |=>
    txOutValid && $stable(txOutData) && $stable(txOutLast)) else $error("tx word lost");
  a_speed_resv: assert property (txSpeedReserved == (txSpeed > 3'h2))
    else $error("reserved speed flag wrong");
  a_err_pulse: assert property (txFormatError |=> !txFormatError)
    else $error("format error not a pulse");
  a_rx_pace: assert property (rxValid && rxReady |=> !rxReady)
    else $error("receive ready held after take");
  a_cs_drop: assert property (csTake |-> ##[1:6] rxDropped)
    else $error("cycle start not flagged");
  a_cs_nostore: assert property (csTake |=> !memWrValid [*3])
    else $error("cycle start stored");
  a_mem_pulse: assert property (memWrValid |=> !memWrValid)
    else $error("memory write too dense");
  a_load_count: assert property (bufLoad[1] |=> resCount[1] == $past(bufCount[1]))
    else $error("buffer load count wrong");
  a_mem_step: assert property (wrNoLoad ##1 (!memWrValid && bufLoad == 2'b00) ##1 wrNoLoad
    |-> memWrAddr == $past(memWrAddr, 2) + 32'h4) else $error("write address not stepped");
endmodule : asf_tx_format_chk

bind asf_tx_format asf_tx_format_chk asf_tx_format_chk_i (
  .clk(clk), .rst_n(rst_n), .txOutValid(txOutValid), .txOutReady(txOutReady),
  .txOutData(txOutData), .txOutLast(txOutLast), .txSpeed(txSpeed),
  .txSpeedReserved(txSpeedReserved), .txFormatError(txFormatError), .rxValid(rxValid),
  .rxReady(rxReady), .rxData(rxData), .rxFirst(rxFirst), .bufLoad(bufLoad),
  .bufCount(bufCount), .resCount(resCount), .memWrValid(memWrValid), .memWrCtx(memWrCtx),
  .memWrAddr(memWrAddr), .rxDropped(rxDropped));

// ### sim/asf_link_model.sv
// asf_link_model: serial link beside the framer, sinks wire quadlets, offers received ones
// assumes the bench calls sendRx; stalls appear only while slow is high
module asf_link_model (
  // clock and mode
  input wire logic               clk,
  input wire logic               slow,
  // wire transmit sink
  output     logic               txOutReady,
  // receive source
  output     logic               rxValid,
  input wire logic               rxReady,
  output     asf_pkg::asf_quad_t rxData,
  output     logic               rxFirst
);
  timeunit 1ns;
  timeprecision 1ps;
  import asf_pkg::*;
  initial begin
    txOutReady = 1'b1;
    rxValid = 1'b0;
    rxData = '0;
    rxFirst = 1'b0;
  end
  always @(negedge clk) begin
    txOutReady <= !slow || ($urandom_range(3) != 0);
  end
  task automatic sendRx(input asf_quad_t w[$]);
    foreach (w[i]) begin
      @(negedge clk);
      rxValid = 1'b1;
      rxData  = w[i];
      rxFirst = (i == 0);
      while (!rxReady) @(negedge clk);
      @(posedge clk);
    end
    @(negedge clk);
    rxValid = 1'b0;
    rxFirst = 1'b0;
    // released data flips so a stale word is never mistaken for a new one
    rxData  = ~rxData;
  endtask : sendRx
endmodule : asf_link_model

// ### sim/asf_tx_format_tb.sv
// asf_tx_format_tb: self-checking bench for the response/stream framer
// assumes asf_link_model as far side and the checker bound to the framer
module asf_tx_format_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import asf_pkg::*;
  logic       clk, rst_n, slow, txInValid, txInReady, txInLast, txOutValid, txOutReady;
  logic       txOutLast, txIsStream, txSpeedReserved, txFormatError, rxValid, rxReady;
  logic       rxFirst, memWrValid, memWrCtx, rxDropped;
  logic [9:0] busNumber;
  logic [5:0] nodeNumber;
  logic [2:0] txSpeed;
  logic [1:0] bufLoad;
  logic [31:0] bufAddr [2];
  logic [31:0] memWrAddr;
  asf_quad_t  txInData, txOutData, rxData, memWrData;
  asf_count_t bufCount [2];
  asf_count_t resCount [2];
  logic [32:0] expTx[$];
  logic [64:0] expMem[$];
  logic [3:0] tcs [5] = '{4'h2, 4'h6, 4'h7, 4'ha, 4'hb};
  int         failCount, nCompared, cycles, errSeen, dropSeen, errExp, dropExp, nBase, nCnt;
  int         mAddr [2];
  int         mLeft [2];

  asf_tx_format asf_tx_format_i (.clk(clk), .rst_n(rst_n), .busNumber(busNumber),
    .nodeNumber(nodeNumber), .txInValid(txInValid), .txInReady(txInReady),
    .txInData(txInData), .txInLast(txInLast), .txOutValid(txOutValid),
    .txOutReady(txOutReady), .txOutData(txOutData), .txOutLast(txOutLast),
    .txSpeed(txSpeed), .txSpeedReserved(txSpeedReserved), .txIsStream(txIsStream),
    .txFormatError(txFormatError), .rxValid(rxValid), .rxReady(rxReady), .rxData(rxData),
    .rxFirst(rxFirst), .bufLoad(bufLoad), .bufAddr(bufAddr), .bufCount(bufCount),
    .resCount(resCount), .memWrValid(memWrValid), .memWrCtx(memWrCtx),
    .memWrAddr(memWrAddr), .memWrData(memWrData), .rxDropped(rxDropped));
  asf_link_model asf_link_model_i (.clk(clk), .slow(slow), .txOutReady(txOutReady),
    .rxValid(rxValid), .rxReady(rxReady), .rxData(rxData), .rxFirst(rxFirst));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic conclude();
    $display("compared %0d, mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic compare(input logic [64:0] got, input logic [64:0] exp);
    nCompared++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : compare
  task automatic checkTx(input logic [32:0] got);
    compare(got, expTx.size() ? expTx.pop_front() : 'x);
  endtask : checkTx
  task automatic checkMem(input logic [64:0] got);
    compare(got, expMem.size() ? expMem.pop_front() : 'x);
  endtask : checkMem
  always @(posedge clk) begin
    if (rst_n && txOutValid && txOutReady) checkTx({txOutLast, txOutData});
    if (rst_n && memWrValid) checkMem({memWrCtx, memWrAddr, memWrData});
    errSeen += rst_n && txFormatError;
    dropSeen += rst_n && rxDropped;
    cycles++;
    if (cycles == 20000) begin
      failCount++;
      conclude();
    end
  end
  task automatic sendTx(input asf_quad_t w[$]);
    foreach (w[i]) begin
      @(negedge clk);
      txInValid = 1'b1;
      txInData  = w[i];
      txInLast  = (i == w.size() - 1);
      while (!txInReady) @(negedge clk);
      @(posedge clk);
    end
    @(negedge clk);
    txInValid = 1'b0;
    txInData  = ~txInData;
  endtask : sendTx
  task automatic txPkt(input logic [3:0] tc, input int len, input logic sel,
                       input logic [2:0] spd);
    asf_quad_t w[$];
    asf_quad_t q0, q1, d;
    logic      strm, pay;
    int        n0;
    n0 = expTx.size();
    strm = (tc == 4'ha);
    pay = strm || tc == 4'h7 || tc == 4'hb;
    q0 = strm ? {13'h0, spd, 8'($urandom), tc, 4'($urandom)}
              : {8'h0, sel, 4'h0, spd, 6'($urandom), 2'b01, tc, 4'h0};
    q1 = strm ? {16'(len), 16'h0} : {16'($urandom), 4'($urandom), 12'h0};
    w = '{q0, q1};
    if (!strm) w.push_back(32'h0);
    if (strm) expTx.push_back({1'b0, 16'(len), q0[15:0]});
    else if (tc inside {4'h2, 4'h6, 4'h7, 4'hb}) begin
      expTx.push_back({1'b0, q1[31:16], q0[15:10], 2'b01, tc, 4'h0});
      expTx.push_back({1'b0, sel ? busNumber : 10'h3ff, nodeNumber, q1[15:12], 12'h0});
      expTx.push_back(33'h0);
    end else errExp++;
    if (tc inside {4'h6, 4'h7, 4'hb}) begin
      d = (tc == 4'h6) ? $urandom : {16'(len), tc == 4'hb ? 16'($urandom) : 16'h0};
      w.push_back(d);
      expTx.push_back({1'b0, d});
    end
    for (int j = 0; pay && j < (len + 3) / 4; j++) begin
      d = $urandom;
      w.push_back(d);
      for (int k = 0; k < 4; k++) if (j * 4 + k >= len) d[31 - 8 * k -: 8] = 8'h0;
      expTx.push_back({1'b0, d});
    end
    if (expTx.size() > n0) expTx[$][32] = 1'b1;
    sendTx(w);
    if (tc != 4'h1) compare({txIsStream, txSpeed, txSpeedReserved}, {strm, spd, spd > 3'h2});
  endtask : txPkt
  task automatic loadBuf(input int c, input int base, input int cnt);
    @(negedge clk);
    bufAddr[c] = 32'(base);
    bufCount[c] = 16'(cnt);
    bufLoad[c] = 1'b1;
    @(negedge clk);
    bufLoad = 2'b00;
  endtask : loadBuf
  task automatic rxPkt(input logic [3:0] tc, input int n);
    asf_quad_t w[$];
    int        c;
    c = (tc inside {4'h2, 4'h6, 4'h7, 4'hb});
    for (int i = 0; i < n; i++) begin
      w.push_back(i ? $urandom : {24'($urandom), tc, 4'h0});
      if (tc != 4'h8) begin
        if (mLeft[c] < 4) begin
          mAddr[c] = nBase;
          mLeft[c] = nCnt;
        end
        expMem.push_back({c[0], 32'(mAddr[c]), w[i]});
        mAddr[c] += 4;
        mLeft[c] -= 4;
      end
    end
    dropExp += (tc == 4'h8);
    asf_link_model_i.sendRx(w);
  endtask : rxPkt

  initial begin
    void'($urandom(34));
    {rst_n, slow, txInValid, txInLast, bufLoad} = '0;
    txInData = '0;
    busNumber = 10'($urandom);
    nodeNumber = 6'($urandom);
    bufAddr = '{32'h0, 32'h0};
    bufCount = '{16'h0, 16'h0};
    repeat (20) @(negedge clk);
    compare({txOutValid, memWrValid, rxReady, resCount[0], resCount[1]}, 35'h0);
    rst_n = 1'b1;
    txPkt(4'h6, 0, 1'b0, 3'h0);
    txPkt(4'h7, 5, 1'b1, 3'h1);
    txPkt(4'hb, 8, 1'b0, 3'h2);
    txPkt(4'h7, 0, 1'b1, 3'h0);
    txPkt(4'h2, 0, 1'b1, 3'h1);
    txPkt(4'ha, 5, 1'b0, 3'h2);
    txPkt(4'ha, 7, 1'b0, 3'h5);
    txPkt(4'h1, 0, 1'b0, 3'h0);
    slow = 1'b1;
    repeat (12) txPkt(tcs[$urandom_range(4)], $urandom_range(13, 1), 1'($urandom),
                      3'($urandom_range(2)));
    for (int i = 0; i < 400 && expTx.size() > 0; i++) @(negedge clk);
    compare({expTx.size(), errSeen}, {32'd0, 32'(errExp)});
    loadBuf(0, 'h1000, 8);
    loadBuf(1, 'h2000, 64);
    mAddr = '{'h1000, 'h2000};
    mLeft = '{8, 64};
    rxPkt(4'h6, 3);
    rxPkt(4'h8, 2);
    rxPkt(4'hb, 2);
    nBase = 'h3000;
    nCnt = 16;
    fork
      rxPkt(4'h0, 3);
      begin
        repeat (60) @(negedge clk);
        compare({expMem.size(), resCount[0]}, 48'h1_0000);
        loadBuf(0, 'h3000, 16);
      end
    join
    repeat (10) @(negedge clk);
    compare({resCount[0], resCount[1]}, {16'(mLeft[0]), 16'(mLeft[1])});
    compare({expMem.size(), dropSeen}, {32'd0, 32'(dropExp)});
    conclude();
  end
endmodule : asf_tx_format_tb
